/* File: bms_host_model.sv */
// Purpose: Host side master model for the mode 0 serial port
// Assumes: Link clock period 12 ns, running only inside frames
// Notes: Driven through tasks called by the testbench
`timescale 1ns/1ps
module bms_host_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso
);
  // ==========================================================
  // Idle levels
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // ==========================================================
  // Checksum, zero start, MSB first, no inversion
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ d[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  // ==========================================================
  // One frame of n bits, MSB first, sampled on rising edge
  task automatic xfer(input logic [23:0] tx, input int n,
                      output logic [23:0] rx);
    rx = 24'h000000;
    cs_n = 1'b0;
    #200;
    for (int i = 0; i < n; i++) begin
      mosi = tx[23 - i];
      #6;
      rx = {rx[22:0], miso};
      sclk = 1'b1;
      #6;
      sclk = 1'b0;
    end
    #100;
    cs_n = 1'b1;
    mosi = ~mosi;
  endtask

  // Select held with clock stopped
  task automatic set_cs(input logic v);
    cs_n = v;
  endtask
endmodule

/* File: bms_pkg.sv */
// Purpose: Shared constants, types and CRC helper for the serial port
// Assumes: mclk at 20 MHz; CRC-8 polynomial 0x07, MSB first, init zero
// Notes: Counts derived from times at the mclk rate
package bms_pkg;

  // ==========================================================
  // Timing
  localparam int MCLK_HZ = 20_000_000;
  localparam int OSC_WAKE_US = 50;
  localparam int OSC_WAKE_CYC = OSC_WAKE_US * (MCLK_HZ / 1_000_000);
  localparam int FILTER_NS = 200;
  localparam int FILTER_CYC = (FILTER_NS * (MCLK_HZ / 1_000_000) + 999)
                              / 1000;
  localparam int IDLE_TIMEOUT_S = 2;
  localparam int SECOND_CYC_DEF = MCLK_HZ;
  localparam int IDLE_TIMEOUT_CYC_DEF = IDLE_TIMEOUT_S * MCLK_HZ;
  localparam logic [7:0] MIN_HOLD_S = 8'h01;
  localparam int DIRECT_CMD_US = 50;
  localparam int SUBCMD_LOAD_US = 200;

  // ==========================================================
  // Frame layout and flag patterns
  localparam logic [4:0] BITS_NO_CRC = 5'h10;
  localparam logic [4:0] BITS_CRC = 5'h18;
  localparam logic [4:0] LAST_BIT = 5'h17;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [7:0] CRC_BAD_MARK = 8'haa;
  localparam logic [7:0] NOT_READY_CRC = 8'hff;
  localparam logic [7:0] STALE_CRC = 8'h00;
  localparam logic [15:0] FLAG_WORD = 16'hffff;
  localparam logic [6:0] GUARD_ADDR = 7'h7f;
  localparam logic [7:0] GUARD_DATA = 8'hff;
  localparam logic [6:0] SUBBUF_LO = 7'h40;
  localparam logic [6:0] SUBBUF_HI = 7'h5f;
  localparam logic RW_WRITE = 1'b1;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    OB_STALE = 3'b001,
    OB_FRESH = 3'b010,
    OB_CRCERR = 3'b100
  } bms_obuf_type;

  typedef struct packed {
    logic rw;
    logic [6:0] addr;
    logic [7:0] data;
  } bms_frame_type;

  typedef struct packed {
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [1:0] flt;
    logic [1:0][2:0] fcnt;
    logic cs_prev;
    logic sclk_prev;
    logic tog_seen;
    logic osc_on;
    logic osc_ready;
    logic [9:0] warm;
    logic [7:0] hold_s;
    logic [31:0] sec_cnt;
    logic [31:0] idle_cnt;
    logic frame_ok;
    logic link_clr;
    logic [23:0] tx_word;
    logic [15:0] out_buf;
    bms_obuf_type ob;
    logic pend;
    bms_frame_type pend_f;
    logic rx_valid;
    bms_frame_type rx_f;
    logic frame_err;
    logic crc_err;
    logic port_reset;
    logic supply;
  } bms_core_type;

  typedef struct packed {
    logic tog;
    logic [4:0] cnt;
    logic [23:0] sh;
  } bms_link_type;

  localparam bms_core_type CORE_RST = '{
    sy1: 3'h1, sy2: 3'h1, flt: 2'h1, fcnt: '0, cs_prev: 1'b1,
    sclk_prev: 1'b0, tog_seen: 1'b0, osc_on: 1'b0, osc_ready: 1'b0,
    warm: 10'h000, hold_s: 8'h00, sec_cnt: 32'h0, idle_cnt: 32'h0,
    frame_ok: 1'b0, link_clr: 1'b1, tx_word: 24'hffffff,
    out_buf: 16'hffff, ob: OB_STALE, pend: 1'b0, pend_f: '0,
    rx_valid: 1'b0, rx_f: '0, frame_err: 1'b0, crc_err: 1'b0,
    port_reset: 1'b0, supply: 1'b0};

  localparam bms_link_type LINK_RST = '{tog: 1'b0, cnt: 5'h00,
                                        sh: 24'h000000};

  // CRC-8 over two bytes, MSB first, no final inversion
  function automatic logic [7:0] bms_crc8(input logic [15:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 15; i >= 0; i--) begin
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

endpackage

/* File: bms_spi_slave.sv */
// Purpose: Slave-only mode 0 serial port with echo buffers and optional CRC
// Assumes: sclk idles low and stops outside frames; mclk runs free
// Notes: Oscillator warm-up and hold are modelled as a ready state
//
// Functional notes
// R1: Mode 0: clock idles low, data captured on rising clock edge.
// R2: Optional checksum is CRC-8 with polynomial x^8+x^2+x+1.
// R3: Master clocks exactly 16 bits, or 24 bits with checksum on.
// R4: Protocol select fixes CRC mode; bad CRC or wrong length is refused.
// R5: Write with wrong CRC: drop data, buffer 0xFFFF, next CRC 0xAA.
// R6: Oscillator off at frame start: send 0xFFFF, and 0xFF as CRC.
// R7: Chip select fall wakes oscillator, usable after up to 50 us.
// R8: Write of 0xFF to address 0x7F is never accepted.
// R9: Oscillator held on 0 to 255 s after wake, at least 1 s.
// R10: Master leaves at least 50 us between transactions.
// R11: Select low with static clock for two seconds resets port logic.
// R12: Data-out supply choice applies only after a switch/apply command.
// R13: Input pins pass a 200 ns filter, on unless bypassed; code filters only mclk views of select and clock.
// R14: First byte is direction bit then 7-bit address, MSB first.
// R15: Write takes second byte as data; read ignores it except CRC.
// R16: Third byte is master CRC over first two bytes; good CRC accepts.
// R17: Buffer not refreshed since last frame: send 0xFFFF and CRC 0x00.
// R18: After a write, echo direction, address and data next frame.
// R19: After a read, return direction, address, data and their CRC.
// R20: Direct commands finish in 50 us; result buffer loads in 200 us.
// R21: Result buffer at 0x40..0x5F; early reads give not-updated pattern.
// R22: Master retries on 0xFFFFFF, 0xFFFFAA and 0xFFFF00.
// R23: CRC starts at zero each frame, MSB first, no final inversion.
`timescale 1ns/1ps
module bms_spi_slave
  import bms_pkg::*;
#(
  parameter int SECOND_CYC = SECOND_CYC_DEF,
  parameter int IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic crc_enable,
  input wire logic input_filter_enable,
  input wire logic [7:0] comm_idle_time,
  input wire logic dataout_supply_select,
  input wire logic switch_to_serial_port_cmd,
  input wire logic apply_comm_select_cmd,
  input wire logic subcmd_buf_ready,
  input wire logic core_done,
  input wire logic [7:0] core_rdata,
  output logic rx_valid,
  output bms_frame_type rx_frame,
  output logic frame_err,
  output logic crc_err,
  output logic port_reset,
  output logic high_freq_oscillator_on,
  output logic osc_ready,
  output logic cmd_pending,
  output logic dataout_supply_active
);

  localparam int WAKE_MAX = OSC_WAKE_CYC;

  // ==========================================================
  // Link domain: shift in on sclk rising edges
  bms_link_type l_q;
  bms_link_type l_d;
  logic first_q;
  logic first_clr;
  bms_core_type s_q;
  bms_core_type s_d;

  assign first_clr = cs_n | s_q.link_clr;

  always_comb begin
    l_d = l_q;
    l_d.sh = {l_q.sh[22:0], mosi}; // R1 R14
    if (first_q) begin
      l_d.cnt = 5'h01;
      l_d.tog = ~l_q.tog;
    end else if (l_q.cnt != 5'h1f) begin
      l_d.cnt = l_q.cnt + 5'h01;
    end
  end

  always_ff @(posedge sclk or posedge s_q.link_clr) begin
    if (s_q.link_clr) begin
      l_q <= LINK_RST;
    end else begin
      l_q <= l_d;
    end
  end

  always_ff @(posedge sclk or posedge first_clr) begin
    if (first_clr) begin
      first_q <= 1'b1;
    end else begin
      first_q <= 1'b0;
    end
  end

  // Word is frozen by mclk while select is low; bit moves after each rise
  always_comb begin
    if (first_q) begin
      miso = s_q.tx_word[23];
    end else if (l_q.cnt > LAST_BIT) begin
      miso = 1'b1;
    end else begin
      miso = s_q.tx_word[LAST_BIT - l_q.cnt];
    end
  end
  assign miso_oe = ~cs_n;

  // ==========================================================
  // Core domain
  logic cs_rise;
  logic cs_fall;
  logic clocked;
  logic [15:0] fr16;
  bms_frame_type fr;
  logic len_ok;
  logic crc_ok;
  logic guard;
  logic subwait;
  logic ev_end;
  logic ev_crcbad;

  always_comb begin
    s_d = s_q;
    s_d.rx_valid = 1'b0;
    s_d.frame_err = 1'b0;
    s_d.crc_err = 1'b0;
    s_d.port_reset = 1'b0;
    s_d.link_clr = 1'b0;
    s_d.sy1 = {l_q.tog, sclk, cs_n};
    s_d.sy2 = s_q.sy1;
    // Glitch filter on select and clock views
    for (int i = 0; i < 2; i++) begin
      if (!input_filter_enable) begin
        s_d.flt[i] = s_q.sy2[i];
        s_d.fcnt[i] = 3'h0;
      end else if (s_q.sy2[i] == s_q.flt[i]) begin
        s_d.fcnt[i] = 3'h0;
      end else if (s_q.fcnt[i] == 3'(FILTER_CYC - 1)) begin
        s_d.flt[i] = s_q.sy2[i]; // R13
        s_d.fcnt[i] = 3'h0;
      end else begin
        s_d.fcnt[i] = s_q.fcnt[i] + 3'h1;
      end
    end
    s_d.cs_prev = s_q.flt[0];
    s_d.sclk_prev = s_q.flt[1];
    cs_rise = s_q.flt[0] & ~s_q.cs_prev;
    cs_fall = ~s_q.flt[0] & s_q.cs_prev;
    clocked = s_q.sy2[2] != s_q.tog_seen;

    // Frame decode; link words are static once select has risen
    fr16 = crc_enable ? l_q.sh[23:8] : l_q.sh[15:0];
    fr = fr16;
    len_ok = clocked && (l_q.cnt == (crc_enable ? BITS_CRC : BITS_NO_CRC));
    crc_ok = bms_crc8(fr16) == l_q.sh[7:0]; // R2 R16 R23
    guard = fr.rw == RW_WRITE && fr.addr == GUARD_ADDR
            && fr.data == GUARD_DATA;
    subwait = fr.rw != RW_WRITE && fr.addr >= SUBBUF_LO
              && fr.addr <= SUBBUF_HI && !subcmd_buf_ready;
    ev_end = cs_rise && s_q.frame_ok;
    ev_crcbad = ev_end && crc_enable && len_ok && !crc_ok
                && fr.rw == RW_WRITE;

    // Oscillator wake, warm-up and hold
    if (cs_fall) begin
      s_d.osc_on = 1'b1; // R7
      s_d.frame_ok = s_q.osc_ready; // R6
      s_d.hold_s = (comm_idle_time < MIN_HOLD_S) ? MIN_HOLD_S
                   : comm_idle_time; // R9
      if (!s_q.osc_on) begin
        s_d.warm = 10'h000;
      end
    end
    if (s_q.osc_on && !s_q.osc_ready) begin
      if (s_q.warm == 10'(OSC_WAKE_CYC - 1)) begin
        s_d.osc_ready = 1'b1; // R7
      end else begin
        s_d.warm = s_q.warm + 10'h001;
      end
    end
    if (!s_q.flt[0] || !s_q.osc_on) begin
      s_d.sec_cnt = 32'h0;
    end else if (s_q.sec_cnt == 32'(SECOND_CYC - 1)) begin
      s_d.sec_cnt = 32'h0;
      if (s_q.hold_s <= MIN_HOLD_S) begin
        s_d.osc_on = 1'b0; // R9
        s_d.osc_ready = 1'b0;
      end else begin
        s_d.hold_s = s_q.hold_s - 8'h01;
      end
    end else begin
      s_d.sec_cnt = s_q.sec_cnt + 32'h1;
    end

    // Stuck-bus watchdog
    if (!s_q.flt[0] && s_q.flt[1] == s_q.sclk_prev) begin
      if (s_q.idle_cnt == 32'(IDLE_TIMEOUT_CYC - 1)) begin
        s_d.idle_cnt = 32'h0;
        s_d.link_clr = 1'b1; // R11
        s_d.port_reset = 1'b1;
        s_d.frame_ok = 1'b0;
        s_d.tog_seen = 1'b0;
      end else begin
        s_d.idle_cnt = s_q.idle_cnt + 32'h1;
      end
    end else begin
      s_d.idle_cnt = 32'h0;
    end

    // Internal logic answers a pending request
    if (core_done && s_q.pend) begin
      s_d.pend = 1'b0;
      s_d.out_buf = {s_q.pend_f.rw, s_q.pend_f.addr,
                     (s_q.pend_f.rw == RW_WRITE) ? s_q.pend_f.data
                     : core_rdata}; // R18 R19 R20
      s_d.ob = OB_FRESH;
    end

    // End of frame
    if (cs_rise) begin
      s_d.tog_seen = s_q.sy2[2];
      s_d.frame_ok = 1'b0;
    end
    if (ev_end) begin
      s_d.ob = OB_STALE; // R17
      if (!len_ok || (crc_enable && !crc_ok)) begin
        s_d.frame_err = 1'b1; // R3 R4
        s_d.crc_err = len_ok;
      end else if (!guard && !subwait) begin
        s_d.rx_valid = 1'b1; // R15 R21 R8
        s_d.rx_f = fr;
        s_d.pend = 1'b1;
        s_d.pend_f = fr;
      end
      if (ev_crcbad) begin
        s_d.out_buf = FLAG_WORD; // R5
        s_d.ob = OB_CRCERR;
      end
    end

    // Outgoing word, only changed while deselected
    if (s_q.flt[0] && s_q.sy2[0]) begin
      if (!s_q.osc_ready) begin
        s_d.tx_word = {FLAG_WORD, NOT_READY_CRC}; // R6
      end else begin
        unique case (s_q.ob)
          OB_STALE: s_d.tx_word = {FLAG_WORD, STALE_CRC}; // R17
          OB_CRCERR: s_d.tx_word = {FLAG_WORD, CRC_BAD_MARK}; // R5 R22
          OB_FRESH: s_d.tx_word = {s_q.out_buf, bms_crc8(s_q.out_buf)};
        endcase
      end
    end

    // Data-out supply choice takes effect on command
    if (switch_to_serial_port_cmd || apply_comm_select_cmd) begin
      s_d.supply = dataout_supply_select; // R12
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      s_q <= CORE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rx_valid = s_q.rx_valid;
  assign rx_frame = s_q.rx_f;
  assign frame_err = s_q.frame_err;
  assign crc_err = s_q.crc_err;
  assign port_reset = s_q.port_reset;
  assign high_freq_oscillator_on = s_q.osc_on;
  assign osc_ready = s_q.osc_ready;
  assign cmd_pending = s_q.pend;
  assign dataout_supply_active = s_q.supply;

  // ==========================================================
  // Assertions
  property p_crc_bad;
    @(posedge mclk) disable iff (!rst_n)
    ev_crcbad |=> s_q.ob == OB_CRCERR && s_q.out_buf == FLAG_WORD
                  && !s_q.rx_valid;
  endproperty
  a_crc_bad: assert property (p_crc_bad) // R5
    else $error("crc error did not load flag pattern");

  property p_not_ready;
    @(posedge mclk) disable iff (!rst_n)
    (!s_q.osc_ready && s_q.flt[0] && s_q.sy2[0])
      |=> s_q.tx_word == 24'hffffff;
  endproperty
  a_not_ready: assert property (p_not_ready) // R6
    else $error("oscillator off but word not all ones");

  property p_stale;
    @(posedge mclk) disable iff (!rst_n)
    (s_q.osc_ready && s_q.ob == OB_STALE && s_q.flt[0] && s_q.sy2[0])
      |=> s_q.tx_word == 24'hffff00;
  endproperty
  a_stale: assert property (p_stale) // R17
    else $error("stale buffer not flagged");

  property p_wake;
    @(posedge mclk) disable iff (!rst_n)
    $rose(s_q.osc_on) |-> !s_q.osc_ready ##[1:WAKE_MAX] s_q.osc_ready;
  endproperty
  a_wake: assert property (p_wake) // R7
    else $error("oscillator not ready within wake time");

  property p_len;
    @(posedge mclk) disable iff (!rst_n)
    (ev_end && !crc_enable && l_q.cnt != 5'h10) |=> frame_err
      && !rx_valid;
  endproperty
  a_len: assert property (p_len) // R4
    else $error("wrong length frame not flagged");

  property p_echo;
    @(posedge mclk) disable iff (!rst_n)
    (core_done && s_q.pend && s_q.pend_f.rw && !ev_end)
      |=> s_q.ob == OB_FRESH && s_q.out_buf == $past(s_q.pend_f);
  endproperty
  a_echo: assert property (p_echo) // R18
    else $error("write not echoed into outgoing buffer");

  property p_guard;
    @(posedge mclk) disable iff (!rst_n)
    rx_valid |-> !(rx_frame.rw && rx_frame.addr == 7'h7f
                   && rx_frame.data == 8'hff);
  endproperty
  a_guard: assert property (p_guard) // R8
    else $error("guarded write accepted");

  property p_supply;
    @(posedge mclk) disable iff (!rst_n)
    !(switch_to_serial_port_cmd || apply_comm_select_cmd)
      |=> $stable(dataout_supply_active);
  endproperty
  a_supply: assert property (p_supply) // R12
    else $error("supply changed without command");

  property p_hold;
    @(posedge mclk) disable iff (!rst_n)
    $fell(s_q.osc_on) |-> $past(s_q.flt[0]) && $past(s_q.hold_s) <= 8'h01;
  endproperty
  a_hold: assert property (p_hold) // R9
    else $error("oscillator dropped before hold ran out");

  property p_subbuf;
    @(posedge mclk) disable iff (!rst_n)
    (ev_end && subwait) |=> !rx_valid && s_q.ob != OB_FRESH;
  endproperty
  a_subbuf: assert property (p_subbuf) // R21
    else $error("early result buffer read forwarded");

endmodule

/* File: bms_spi_slave_tb.sv */
// Purpose: Self-checking bench for the mode 0 serial slave port
// Assumes: One second scaled to 100 mclk, watchdog to 200 mclk
// Notes: Rows hold a frame, the core reply and the expected echo
`timescale 1ns/1ps
module bms_spi_slave_tb;
  import bms_pkg::*;
  typedef struct packed {
    logic [23:0] tx;
    logic cd;
    logic [7:0] rd;
    logic sbr;
    logic [2:0] fl;
    logic [23:0] ex;
  } bms_row_type;
  logic mclk = 1'b0;
  logic rst_n, sclk, cs_n, mosi, miso, miso_oe, crc_enable, input_filter_enable_en;
  logic sup_sel, swap_cmd, apply_cmd, sbr, core_done, rx_valid;
  logic frame_err, crc_err, port_reset, osc_on, osc_ready, cmd_pending;
  logic sup_act;
  logic [7:0] idle_time, core_rdata;
  bms_frame_type rx_frame, rf;
  logic [23:0] rx;
  logic [2:0] fl;
  int fail_count = 0;
  int compares = 0;
  int k;
  bms_row_type rows[$];

  always #25 mclk = ~mclk;

  bms_spi_slave #(.SECOND_CYC(100), .IDLE_TIMEOUT_CYC(200)) i_bms_spi_slave (
    .mclk(mclk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .crc_enable(crc_enable),
    .input_filter_enable(input_filter_enable_en), .comm_idle_time(idle_time),
    .dataout_supply_select(sup_sel), .switch_to_serial_port_cmd(swap_cmd),
    .apply_comm_select_cmd(apply_cmd), .subcmd_buf_ready(sbr),
    .core_done(core_done), .core_rdata(core_rdata), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .frame_err(frame_err), .crc_err(crc_err),
    .port_reset(port_reset), .high_freq_oscillator_on(osc_on),
    .osc_ready(osc_ready), .cmd_pending(cmd_pending),
    .dataout_supply_active(sup_act));

  bms_host_model i_bms_host_model (
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

  // ==========================================================
  // Helpers
  function automatic logic [23:0] frm(input logic [15:0] w, input logic b);
    return {w, i_bms_host_model.crc8(w) ^ {7'h00, b}};
  endfunction

  task automatic check(input logic [23:0] s, input logic [23:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic finish_test();
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic run_frame(input logic [23:0] tx, input int n);
    fl = 3'b000;
    i_bms_host_model.xfer(tx, n, rx);
    repeat (30) begin
      @(posedge mclk);
      #1;
      fl = fl | {rx_valid, frame_err, crc_err};
    end
    rf = rx_frame;
  endtask

  task automatic gap();
    repeat (1100) @(negedge mclk);
  endtask

  task automatic wait_for(input int sel, input int lim);
    for (k = 0; k < lim; k++) begin
      @(posedge mclk);
      #1;
      if ((sel == 0) ? (port_reset === 1'b1) : (osc_on === 1'b0)) break;
    end
    if (k == lim) begin
      fail_count++;
      finish_test();
    end
  endtask

  task automatic add(input logic [23:0] tx, input logic cd,
                     input logic [7:0] rd, input logic s,
                     input logic [2:0] f, input logic [23:0] ex);
    rows.push_back('{tx, cd, rd, s, f, ex});
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    crc_enable = 1'b1;
    input_filter_enable_en = 1'b1;
    idle_time = 8'h20;
    {sup_sel, swap_cmd, apply_cmd, sbr, core_done} = 5'h00;
    core_rdata = 8'h00;
    repeat (10) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
    check({osc_on, osc_ready, rx_valid, frame_err, port_reset}, 5'h00);
    check(miso_oe, 1'b0);
    add(frm(16'h92a5, 0), 0, 8'h00, 0, 3'b000, 24'hffffff);
    add(frm(16'h92a5, 0), 1, 8'h00, 0, 3'b100, 24'hffff00);
    add(frm(16'h0500, 0), 1, 8'h3c, 0, 3'b100, frm(16'h92a5, 0));
    add(frm(16'h92a5, 1), 0, 8'h00, 0, 3'b011, frm(16'h053c, 0));
    add(frm(16'hffff, 0), 0, 8'h00, 0, 3'b000, 24'hffffaa);
    add(frm(16'h4000, 0), 0, 8'h00, 0, 3'b000, 24'hffff00);
    add(frm(16'h8101, 0), 1, 8'h00, 0, 3'b100, 24'hffff00);
    add(frm(16'h4100, 0), 1, 8'h77, 1, 3'b100, frm(16'h8101, 0));
    add(frm(16'h0500, 0), 1, 8'h5a, 1, 3'b100, frm(16'h4177, 0));
    foreach (rows[i]) begin
      sbr = rows[i].sbr;
      if (i == 1) check(osc_ready, 1'b1);
      run_frame(rows[i].tx, 24);
      check(rx, rows[i].ex);
      check(fl, rows[i].fl);
      if (i == 0) check({osc_on, osc_ready}, 2'b10);
      if (fl[2] === 1'b1) check(rf[15:8], rows[i].tx[23:16]);
      if (fl[2] === 1'b1 && rows[i].tx[23]) check(rf, rows[i].tx[23:8]);
      if (rows[i].cd) begin
        @(negedge mclk);
        check(cmd_pending, 1'b1);
        core_done = 1'b1;
        core_rdata = rows[i].rd;
        @(negedge mclk);
        core_done = 1'b0;
        check(cmd_pending, 1'b0);
      end
      gap();
    end
    // Short frame with the pin filter bypassed
    input_filter_enable_en = 1'b0;
    run_frame(frm(16'h8101, 0), 20);
    check(fl, 3'b010);
    input_filter_enable_en = 1'b1;
    gap();
    // Select stuck low with clock stopped
    i_bms_host_model.set_cs(1'b0);
    wait_for(0, 400);
    check(k >= 190, 1'b1);
    check(miso_oe, 1'b1);
    i_bms_host_model.set_cs(1'b1);
    gap();
    // Data-out supply switch
    sup_sel = 1'b1;
    repeat (5) @(negedge mclk);
    check(sup_act, 1'b0);
    swap_cmd = 1'b1;
    @(negedge mclk);
    swap_cmd = 1'b0;
    check(sup_act, 1'b1);
    sup_sel = 1'b0;
    apply_cmd = 1'b1;
    @(negedge mclk);
    apply_cmd = 1'b0;
    check(sup_act, 1'b0);
    // Frames without checksum: 16 clocks taken, 17 refused
    crc_enable = 1'b0;
    gap();
    run_frame({16'h8123, 8'h00}, 16);
    check({rx, fl}, {24'h00ffff, 3'b100});
    check(rf, 16'h8123);
    gap();
    run_frame({16'h8123, 8'h00}, 17);
    check(fl, 3'b010);
    crc_enable = 1'b1;
    gap();
    // Zero hold means one second, then oscillator drops
    idle_time = 8'h00;
    run_frame(frm(16'h0500, 0), 24);
    repeat (40) @(posedge mclk);
    #1;
    check(osc_on, 1'b1);
    wait_for(1, 400);
    gap();
    run_frame(frm(16'h0500, 0), 24);
    check({rx, fl}, {24'hffffff, 3'b000});
    // Second reset in mid-run
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    check({osc_on, osc_ready, cmd_pending, rx_valid}, 4'h0);
    rst_n = 1'b1;
    @(negedge mclk);
    @(negedge mclk);
    check({osc_on, osc_ready, rx_valid, frame_err, port_reset}, 5'h00);
    run_frame(frm(16'h0500, 0), 24);
    check({rx, fl}, {24'hffffff, 3'b000});
    finish_test();
  end
endmodule
